// *** src/scdma_params.svh ***
// register offsets, field positions, reset values and timing counts of the dma channel
`ifndef SCDMA_PARAMS_SVH
`define SCDMA_PARAMS_SVH

`define SCDMA_OFS_STATUS 6'h00
`define SCDMA_OFS_ERROR 6'h01
`define SCDMA_OFS_DEVCTL 6'h04
`define SCDMA_OFS_OPCTL 6'h05
`define SCDMA_OFS_SEQ 6'h06
`define SCDMA_OFS_CHCTL 6'h07
`define SCDMA_OFS_CNT_HI 6'h0a
`define SCDMA_OFS_CNT_LO 6'h0b
`define SCDMA_OFS_ADR_TOP 6'h0c
`define SCDMA_OFS_ADR_MH 6'h0d
`define SCDMA_OFS_ADR_ML 6'h0e
`define SCDMA_OFS_ADR_LO 6'h0f
`define SCDMA_OFS_VEC 6'h25
`define SCDMA_OFS_VEC_ERR 6'h27
`define SCDMA_OFS_PRIO 6'h2d

`define SCDMA_BIT_REQ_MODE 7
`define SCDMA_BIT_DIR 7
`define SCDMA_BIT_START 7
`define SCDMA_BIT_ABORT 4
`define SCDMA_BIT_INT_EN 3
`define SCDMA_BIT_COC 7
`define SCDMA_BIT_NDT 5
`define SCDMA_BIT_ERR 4
`define SCDMA_BIT_ACT 3

`define SCDMA_RST_VEC 8'h0f
`define SCDMA_NULL_READ 8'hff
`define SCDMA_DEVCTL_FIXED 8'h30
`define SCDMA_OPCTL_FIXED 8'h02
`define SCDMA_SEQ_FIXED 8'h40
`define SCDMA_ERR_NONE 5'h00
`define SCDMA_ERR_BUS 5'h09
`define SCDMA_ERR_ABORT 5'h11

`define SCDMA_SYNC_STAGES 2
`define SCDMA_DTC_CYCLES 1

`endif

// *** src/scdma_pkg.sv ***
// types shared by the dma channel
package scdma_pkg;
    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_WORD,
        SZ_LONG,
        SZ_DOUBLE
    } scdma_size_type;

    typedef enum {
        ST_IDLE,
        ST_ARB,
        ST_XFER,
        ST_DTC
    } scdma_state_type;
endpackage

// *** src/scdma_core.sv ***
// single channel dma engine: register port, request handling and bus sequencing
`timescale 1ns/100ps
`include "scdma_params.svh"

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - burst mode: request held from acknowledge to complete starts next operand.
// - burst mode: request dropped before complete releases bus, waits idle.
// - cycle steal: extra edges before first part acknowledged are ignored.
// - cycle steal: release bus after service unless a new request came before complete.
// - byte size: address plus one, upper strobe on even, lower on odd.
// - word size: address plus two, both strobes, count once per word.
// - long size: two word transfers, address plus two each, count once.
// - double size: one transfer, address plus four, bit one low, both strobes.
// - operation control bit 7 chooses memory-to-device or device-to-memory.
// - device control bit 3 reads as OR of the two operand size bits.
// - unused register bits always read their fixed defaults.
// - every register is a byte, grouped so wider moves also work.
// - address bit zero low selects upper lane, high selects lower lane.
// - sequence, top address and priority writes complete but do nothing.
// - error code: 00000 none, 01001 bus error, 10001 software abort.
// - start drops pending requests, clears start, sets active, then serves.
// - start is refused while any of status bits 7 down to 1 is set.
// - reset sets control, status, error and vector; counters and priority kept.
// - status completion, termination and error clear only where a one is written.
// - abort stops, sets completion and error, clears active and start, codes abort.
module scdma_core #(
    parameter int ADDR_W = 24,
    parameter int COUNT_W = 16
) (
    input wire logic ref_clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic chip_select_n, // register access select pin
    input wire logic reg_read, // 1 read, 0 write
    input wire logic [7:0] reg_addr, // register address, bit 0 is the byte lane
    input wire logic [7:0] reg_wdata, // register write data
    output logic [7:0] reg_rdata, // register read data
    output logic reg_dtack_n, // register access done
    input wire logic device_request_n, // device request
    input wire logic device_ready_n, // device ready
    output logic device_acknowledge_n, // request acknowledge
    output logic device_transfer_complete_n, // transfer complete strobe
    output logic done_n, // last operand of the block
    output logic bus_request_n, // bus request
    input wire logic bus_grant_n, // bus grant
    output logic own_n, // bus ownership
    output logic [ADDR_W-1:1] mem_addr, // memory word address
    output logic mem_read, // 1 memory read, 0 memory write
    output logic upper_byte_strobe_n, // upper data strobe
    output logic lower_byte_strobe_n, // lower data strobe
    input wire logic mem_dtack_n, // memory acknowledge
    input wire logic bus_error_n // bus error from error logic
);
    localparam int NSYNC = 6;
    localparam int I_CS = 0;
    localparam int I_REQ = 1;
    localparam int I_RDY = 2;
    localparam int I_GNT = 3;
    localparam int I_DTK = 4;
    localparam int I_BER = 5;

    //////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync_ff [`SCDMA_SYNC_STAGES];
    assign raw_in = {bus_error_n, mem_dtack_n, bus_grant_n, device_ready_n,
                     device_request_n, chip_select_n};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync_ff[0] <= '1;
        end else begin
            sync_ff[0] <= raw_in;
        end
    end

    genvar gs;
    generate
        for (gs = 1; gs < `SCDMA_SYNC_STAGES; gs++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    sync_ff[gs] <= '1;
                end else begin
                    sync_ff[gs] <= sync_ff[gs-1];
                end
            end
        end
    endgenerate

    logic cs_act, req_act, rdy_act, gnt_act, dtk_act, ber_act;
    assign cs_act = ~sync_ff[`SCDMA_SYNC_STAGES-1][I_CS];
    assign req_act = ~sync_ff[`SCDMA_SYNC_STAGES-1][I_REQ];
    assign rdy_act = ~sync_ff[`SCDMA_SYNC_STAGES-1][I_RDY];
    assign gnt_act = ~sync_ff[`SCDMA_SYNC_STAGES-1][I_GNT];
    assign dtk_act = ~sync_ff[`SCDMA_SYNC_STAGES-1][I_DTK];
    assign ber_act = ~sync_ff[`SCDMA_SYNC_STAGES-1][I_BER];

    //////////////////////////////////////////////////////////////////////////
    // register access strobes, one per select
    logic acc_done_ff, acc, wr;
    logic [5:0] ofs;
    assign acc = cs_act & ~acc_done_ff;
    assign wr = acc & ~reg_read;
    assign ofs = reg_addr[5:0];

    function automatic logic hit(input logic [5:0] o, input logic [5:0] a);
        return o == a;
    endfunction

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc_done_ff <= 1'b0;
        end else begin
            acc_done_ff <= cs_act;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // control registers
    logic mode_ff, dir_ff, start_ff, int_en_ff;
    logic [1:0] size_ff;
    logic [7:0] vec_ff;
    logic [COUNT_W-1:0] count_ff;
    logic [ADDR_W-1:0] mac_ff;
    logic coc_ff, ndt_ff, err_ff, act_ff, last_ff;
    logic [4:0] code_ff;
    logic abort_wr, start_wr, start_ok, go;
    logic [7:0] status_rd;

    assign abort_wr = wr & hit(ofs, `SCDMA_OFS_CHCTL) & reg_wdata[`SCDMA_BIT_ABORT];
    assign start_wr = wr & hit(ofs, `SCDMA_OFS_CHCTL) & reg_wdata[`SCDMA_BIT_START];
    assign start_ok = ~(coc_ff | ndt_ff | err_ff | act_ff);
    assign go = start_ff & ~abort_wr;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_ff <= 1'b0;
            dir_ff <= 1'b0;
            size_ff <= 2'h0;
            int_en_ff <= 1'b0;
            vec_ff <= `SCDMA_RST_VEC;
        end else if (wr) begin
            if (hit(ofs, `SCDMA_OFS_DEVCTL)) begin
                mode_ff <= reg_wdata[`SCDMA_BIT_REQ_MODE];
            end else if (hit(ofs, `SCDMA_OFS_OPCTL)) begin
                dir_ff <= reg_wdata[`SCDMA_BIT_DIR];
                size_ff <= reg_wdata[5:4];
            end else if (hit(ofs, `SCDMA_OFS_CHCTL)) begin
                int_en_ff <= reg_wdata[`SCDMA_BIT_INT_EN];
            end else if (hit(ofs, `SCDMA_OFS_VEC) || hit(ofs, `SCDMA_OFS_VEC_ERR)) begin
                vec_ff <= reg_wdata;
            end
        end
    end

    // start is only cleared by reset, by starting or by abort
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            start_ff <= 1'b0;
        end else if (abort_wr || start_ff) begin
            start_ff <= 1'b0;
        end else if (start_wr && start_ok) begin
            start_ff <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // transfer state machine
    scdma_pkg::scdma_state_type state_ff, nxt_state;
    logic part_ff, nxt_part, op_start, xfer_end, finish;
    logic burst_ok_ff, cs_pend_ff, req_prev_ff, have_req, ack_free_ff;
    scdma_pkg::scdma_size_type sz;
    assign sz = scdma_pkg::scdma_size_type'(size_ff);
    assign have_req = mode_ff ? cs_pend_ff : req_act;
    assign xfer_end = (state_ff == scdma_pkg::ST_XFER) & dtk_act & rdy_act & ~ber_act
                      & ack_free_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_part = part_ff;
        op_start = 1'b0;
        finish = 1'b0;
        case (state_ff)
            scdma_pkg::ST_IDLE: begin
                if (act_ff && !go && have_req) begin
                    nxt_state = scdma_pkg::ST_ARB;
                end
            end
            scdma_pkg::ST_ARB: begin
                if (!mode_ff && !req_act) begin
                    nxt_state = scdma_pkg::ST_IDLE;
                end else if (gnt_act) begin
                    nxt_state = scdma_pkg::ST_XFER;
                    op_start = 1'b1;
                    nxt_part = 1'b0;
                end
            end
            scdma_pkg::ST_XFER: begin
                if (ber_act) begin
                    nxt_state = scdma_pkg::ST_IDLE;
                end else if (xfer_end) begin
                    nxt_state = scdma_pkg::ST_DTC;
                end
            end
            scdma_pkg::ST_DTC: begin
                if (sz == scdma_pkg::SZ_LONG && !part_ff) begin
                    nxt_state = scdma_pkg::ST_XFER;
                    nxt_part = 1'b1;
                end else if (last_ff) begin
                    nxt_state = scdma_pkg::ST_IDLE;
                    finish = 1'b1;
                end else if (mode_ff ? cs_pend_ff : (burst_ok_ff && req_act)) begin
                    nxt_state = scdma_pkg::ST_XFER;
                    nxt_part = 1'b0;
                    op_start = 1'b1;
                end else begin
                    nxt_state = scdma_pkg::ST_IDLE;
                end
            end
            default: nxt_state = scdma_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst || abort_wr) begin
            state_ff <= scdma_pkg::ST_IDLE;
            part_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            part_ff <= nxt_part;
        end
    end

    // burst: request must hold from acknowledge through complete
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            burst_ok_ff <= 1'b0;
        end else if (op_start) begin
            burst_ok_ff <= req_act;
        end else if (!req_act) begin
            burst_ok_ff <= 1'b0;
        end
    end

    // synced acknowledge of the previous part lags; it must drop before a new part ends
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_free_ff <= 1'b1;
        end else if (xfer_end) begin
            ack_free_ff <= 1'b0;
        end else if (!dtk_act) begin
            ack_free_ff <= 1'b1;
        end
    end

    // cycle steal: one pending falling edge, freed when acknowledged
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_prev_ff <= 1'b0;
            cs_pend_ff <= 1'b0;
        end else begin
            req_prev_ff <= req_act;
            if (req_act && !req_prev_ff && !go) begin
                cs_pend_ff <= 1'b1;
            end else if (go || (op_start && mode_ff)) begin
                cs_pend_ff <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // counters, no reset
    logic [2:0] step;
    always_comb begin
        case (sz)
            scdma_pkg::SZ_BYTE: step = 3'h1;
            scdma_pkg::SZ_DOUBLE: step = 3'h4;
            default: step = 3'h2;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (wr && hit(ofs, `SCDMA_OFS_CNT_HI)) begin
            count_ff[COUNT_W-1:8] <= reg_wdata[COUNT_W-9:0];
        end else if (wr && hit(ofs, `SCDMA_OFS_CNT_LO)) begin
            count_ff[7:0] <= reg_wdata;
        end else if (op_start) begin
            count_ff <= count_ff - COUNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (op_start) begin
            last_ff <= (count_ff == COUNT_W'(1));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (wr && hit(ofs, `SCDMA_OFS_ADR_MH)) begin
            mac_ff[23:16] <= reg_wdata;
        end else if (wr && hit(ofs, `SCDMA_OFS_ADR_ML)) begin
            mac_ff[15:8] <= reg_wdata;
        end else if (wr && hit(ofs, `SCDMA_OFS_ADR_LO)) begin
            mac_ff[7:0] <= reg_wdata;
        end else if (xfer_end) begin
            mac_ff <= mac_ff + ADDR_W'(step);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // status and error
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            coc_ff <= 1'b0;
            ndt_ff <= 1'b0;
            err_ff <= 1'b0;
            act_ff <= 1'b0;
            code_ff <= `SCDMA_ERR_NONE;
        end else if (abort_wr) begin
            coc_ff <= 1'b1;
            err_ff <= 1'b1;
            act_ff <= 1'b0;
            code_ff <= `SCDMA_ERR_ABORT;
        end else if (state_ff == scdma_pkg::ST_XFER && ber_act) begin
            coc_ff <= 1'b1;
            err_ff <= 1'b1;
            act_ff <= 1'b0;
            code_ff <= `SCDMA_ERR_BUS;
        end else if (finish) begin
            coc_ff <= 1'b1;
            act_ff <= 1'b0;
        end else begin
            if (go) begin
                act_ff <= 1'b1;
            end
            if (wr && hit(ofs, `SCDMA_OFS_STATUS)) begin
                coc_ff <= coc_ff & ~reg_wdata[`SCDMA_BIT_COC];
                ndt_ff <= ndt_ff & ~reg_wdata[`SCDMA_BIT_NDT];
                err_ff <= err_ff & ~reg_wdata[`SCDMA_BIT_ERR];
                if (reg_wdata[`SCDMA_BIT_ERR]) begin
                    code_ff <= `SCDMA_ERR_NONE;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read data and access acknowledge
    assign status_rd = {coc_ff, 1'b0, ndt_ff, err_ff, act_ff, 2'b00, ~rdy_act};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_dtack_n <= 1'b1;
        end else begin
            reg_dtack_n <= ~(cs_act & acc_done_ff);
            if (acc && reg_read) begin
                if (hit(ofs, `SCDMA_OFS_STATUS)) begin
                    reg_rdata <= status_rd;
                end else if (hit(ofs, `SCDMA_OFS_ERROR)) begin
                    reg_rdata <= {3'b000, code_ff};
                end else if (hit(ofs, `SCDMA_OFS_DEVCTL)) begin
                    reg_rdata <= `SCDMA_DEVCTL_FIXED
                        | {mode_ff, 3'b000, |size_ff, 3'b000};
                end else if (hit(ofs, `SCDMA_OFS_OPCTL)) begin
                    reg_rdata <= `SCDMA_OPCTL_FIXED | {dir_ff, 1'b0, size_ff, 4'h0};
                end else if (hit(ofs, `SCDMA_OFS_SEQ)) begin
                    reg_rdata <= `SCDMA_SEQ_FIXED;
                end else if (hit(ofs, `SCDMA_OFS_CHCTL)) begin
                    reg_rdata <= {start_ff, 3'b000, int_en_ff, 3'b000};
                end else if (hit(ofs, `SCDMA_OFS_CNT_HI)) begin
                    reg_rdata <= count_ff[COUNT_W-1:8];
                end else if (hit(ofs, `SCDMA_OFS_CNT_LO)) begin
                    reg_rdata <= count_ff[7:0];
                end else if (hit(ofs, `SCDMA_OFS_ADR_TOP) || hit(ofs, `SCDMA_OFS_PRIO)) begin
                    reg_rdata <= 8'h00;
                end else if (hit(ofs, `SCDMA_OFS_ADR_MH)) begin
                    reg_rdata <= mac_ff[23:16];
                end else if (hit(ofs, `SCDMA_OFS_ADR_ML)) begin
                    reg_rdata <= mac_ff[15:8];
                end else if (hit(ofs, `SCDMA_OFS_ADR_LO)) begin
                    reg_rdata <= mac_ff[7:0];
                end else if (hit(ofs, `SCDMA_OFS_VEC) || hit(ofs, `SCDMA_OFS_VEC_ERR)) begin
                    reg_rdata <= vec_ff;
                end else begin
                    reg_rdata <= `SCDMA_NULL_READ;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // bus and device outputs
    logic in_xfer;
    assign in_xfer = (state_ff == scdma_pkg::ST_XFER);
    assign bus_request_n = ~(state_ff == scdma_pkg::ST_ARB);
    assign own_n = ~(in_xfer | (state_ff == scdma_pkg::ST_DTC));
    assign device_acknowledge_n = ~in_xfer;
    assign device_transfer_complete_n = ~(state_ff == scdma_pkg::ST_DTC);
    assign done_n = ~(in_xfer & last_ff);
    assign mem_read = ~dir_ff;
    assign mem_addr = {mac_ff[ADDR_W-1:2], mac_ff[1] & (sz != scdma_pkg::SZ_DOUBLE)};
    assign upper_byte_strobe_n = ~(in_xfer
        & ((sz != scdma_pkg::SZ_BYTE) | ~mac_ff[0]));
    assign lower_byte_strobe_n = ~(in_xfer
        & ((sz != scdma_pkg::SZ_BYTE) | mac_ff[0]));

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    start_refused_a: assert property (
        (start_wr && !start_ok && !start_ff) |=> !start_ff)
        else $error("start accepted with status set");
    start_seq_a: assert property ((start_ff && !abort_wr) |=> act_ff && !start_ff)
        else $error("start did not activate channel");
    abort_code_a: assert property (
        abort_wr |=> code_ff == `SCDMA_ERR_ABORT && coc_ff && err_ff && !act_ff
        && state_ff == scdma_pkg::ST_IDLE)
        else $error("abort not recorded");
    byte_step_a: assert property ((xfer_end && sz == scdma_pkg::SZ_BYTE)
        |=> mac_ff == $past(mac_ff) + 24'h1)
        else $error("byte address step wrong");
    dbl_addr_a: assert property ((in_xfer && sz == scdma_pkg::SZ_DOUBLE)
        |-> !mem_addr[1] && !upper_byte_strobe_n && !lower_byte_strobe_n)
        else $error("double transfer address or strobes wrong");
    long_parts_a: assert property (
        (state_ff == scdma_pkg::ST_DTC && sz == scdma_pkg::SZ_LONG
        && !part_ff) |=> in_xfer && count_ff == $past(count_ff))
        else $error("long second part wrong");
    burst_drop_a: assert property (
        (state_ff == scdma_pkg::ST_DTC && !mode_ff && !burst_ok_ff
        && sz != scdma_pkg::SZ_LONG) |=> state_ff == scdma_pkg::ST_IDLE)
        else $error("bus kept after dropped request");
    devctl_bit_a: assert property (
        (acc && reg_read && hit(ofs, `SCDMA_OFS_DEVCTL)) |=> reg_rdata[3] == |size_ff)
        else $error("size flag read wrong");
    status_clear_a: assert property (
        (wr && hit(ofs, `SCDMA_OFS_STATUS) && !reg_wdata[7] && coc_ff) |=> coc_ff)
        else $error("status cleared by zero");

    burst_chain_c: cover property (state_ff == scdma_pkg::ST_DTC ##1 in_xfer && !mode_ff);
    steal_keep_c: cover property (state_ff == scdma_pkg::ST_DTC ##1 in_xfer && mode_ff);
    finish_c: cover property (finish);
    bus_err_c: cover property (in_xfer && ber_act);
endmodule

// *** bench/scdma_mem_model.sv ***
// memory and bus arbiter model facing the channel's bus side
`timescale 1ns/100ps
module scdma_mem_model (
    input wire logic ref_clk, // clock
    input wire logic rst, // reset
    input wire logic bus_request_n, // channel wants the bus
    output logic bus_grant_n, // grant
    input wire logic [23:1] mem_addr, // address
    input wire logic mem_read, // direction
    input wire logic upper_byte_strobe_n, // upper strobe
    input wire logic lower_byte_strobe_n, // lower strobe
    output logic mem_dtack_n, // memory acknowledge
    output logic bus_error_n, // bus error
    input wire logic hold_bus, // withhold grant
    input wire logic fail_next, // answer with bus error
    output int xfers, // bus cycles seen
    output logic [1:0] last_strb, // strobes of last cycle
    output logic last_a1, // address bit one of last cycle
    output logic last_rd // direction of last cycle
);
    logic prev_ff;
    wire logic act = !(upper_byte_strobe_n && lower_byte_strobe_n);
    // acknowledge two cycles after strobes, released one cycle after them
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_grant_n <= 1'b1;
            mem_dtack_n <= 1'b1;
            bus_error_n <= 1'b1;
            prev_ff <= 1'b0;
            xfers <= 0;
        end else begin
            bus_grant_n <= bus_request_n || hold_bus;
            prev_ff <= act;
            mem_dtack_n <= !(act && prev_ff && !fail_next);
            bus_error_n <= !(act && prev_ff && fail_next);
            if (act && !prev_ff) begin
                xfers <= xfers + 1;
                last_strb <= {upper_byte_strobe_n, lower_byte_strobe_n};
                last_a1 <= mem_addr[1];
                last_rd <= mem_read;
            end
        end
    end
endmodule

// *** bench/tb.sv ***
// self-checking bench for the dma channel core
`timescale 1ns/100ps
module tb;
    logic ref_clk = 0, rst = 1, cs_n = 1, rd = 1, req_n = 1, rdy_n = 0, hold = 0, fail = 0;
    logic [7:0] a = 0, wd = 0, rdata, q;
    logic dtack_n, ack_n, dtc_n, done_n, br_n, bg_n, own_n, mrd, uds_n, lds_n, mdt_n, berr_n;
    logic [23:1] maddr;
    logic [1:0] ls;
    logic la1, lrd, ackd = 0, dn = 0, ownq = 1;
    int xfers, x0, d0, o0, dtcs = 0, ownr = 0, miscompares = 0, checks = 0;
    logic [7:0] ra [9] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h25, 8'h0c, 8'h02};
    logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h30, 8'h02, 8'h40, 8'h00, 8'h0f, 8'h00, 8'hff};
    logic [1:0] sz [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
    logic [7:0] ba [5] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h02};
    logic [1:0] es [5] = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h0};
    logic [7:0] ea [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06};
    int en [5] = '{1, 1, 1, 2, 1};
    always #2 ref_clk = ~ref_clk;
    scdma_core scdma_core_i (.ref_clk(ref_clk), .rst(rst), .chip_select_n(cs_n), .reg_read(rd),
        .reg_addr(a), .reg_wdata(wd), .reg_rdata(rdata), .reg_dtack_n(dtack_n),
        .device_request_n(req_n), .device_ready_n(rdy_n), .device_acknowledge_n(ack_n),
        .device_transfer_complete_n(dtc_n), .done_n(done_n), .bus_request_n(br_n),
        .bus_grant_n(bg_n), .own_n(own_n), .mem_addr(maddr), .mem_read(mrd),
        .upper_byte_strobe_n(uds_n), .lower_byte_strobe_n(lds_n), .mem_dtack_n(mdt_n),
        .bus_error_n(berr_n));
    scdma_mem_model scdma_mem_model_i (.ref_clk(ref_clk), .rst(rst), .bus_request_n(br_n),
        .bus_grant_n(bg_n), .mem_addr(maddr), .mem_read(mrd), .upper_byte_strobe_n(uds_n),
        .lower_byte_strobe_n(lds_n), .mem_dtack_n(mdt_n), .bus_error_n(berr_n),
        .hold_bus(hold), .fail_next(fail), .xfers(xfers), .last_strb(ls), .last_a1(la1),
        .last_rd(lrd));
    // device side outputs, sampled mid cycle
    always @(negedge ref_clk) begin
        if (!(uds_n && lds_n) && (ack_n || own_n)) bad("strobes without ack");
        if (!(uds_n && lds_n) && !mdt_n) ackd = 1;
        if (!done_n) dn = 1;
        if (own_n && !ownq) ownr++;
        ownq = own_n;
        if (!dtc_n) begin
            dtcs++;
            if (!ackd) bad("complete without memory acknowledge");
            ackd = 0;
        end
    end
    //////////////////////////////////////////////////////////////////////////////
    task close_out;
        if (miscompares == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task step;
        @(posedge ref_clk);
        #1;
    endtask
    task bad(input string m);
        miscompares++;
        $display("MISMATCH %0t %s", $time, m);
    endtask
    task acc(input logic r, input logic [7:0] ad, input logic [7:0] d);
        int n;
        cs_n = 0;
        rd = r;
        a = ad;
        wd = d;
        n = 0;
        while (dtack_n !== 1'b0) begin
            step;
            if (++n > 20) begin bad("no register acknowledge"); close_out; end
        end
        q = rdata;
        cs_n = 1;
        while (dtack_n !== 1'b1) begin
            step;
            if (++n > 40) begin bad("acknowledge stuck"); close_out; end
        end
        repeat (3) step;
    endtask
    task wr(input logic [7:0] ad, input logic [7:0] d);
        acc(1'b0, ad, d);
    endtask
    task chk(input logic [7:0] ad, input logic [7:0] e);
        acc(1'b1, ad, 8'h00);
        checks++;
        if (q !== e) $display("MISMATCH %0t reg %h got %h exp %h", $time, ad, q, e);
        if (q !== e) miscompares++;
    endtask
    task waitx(input int n);
        int k;
        k = 0;
        while (xfers != n) begin
            step;
            if (++k > 300) begin bad("transfer missing"); close_out; end
        end
    endtask
    task poll(input logic [7:0] m);
        int k;
        k = 0;
        acc(1'b1, 8'h00, 8'h00);
        while ((q & m) !== m) begin
            acc(1'b1, 8'h00, 8'h00);
            if (++k > 30) begin bad("status never set"); close_out; end
        end
    endtask
    task run(input logic [7:0] cnt, input logic [7:0] adr);
        wr(8'h0a, 8'h00);
        wr(8'h0b, cnt);
        wr(8'h0d, 8'h00);
        wr(8'h0e, 8'h01);
        wr(8'h0f, adr);
        wr(8'h07, 8'h80);
    endtask
    task pulse;
        req_n = 0;
        repeat (3) step;
        req_n = 1;
        repeat (3) step;
    endtask
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) step;
        rst = 0;
        step;
        for (int i = 0; i < 9; i++) chk(ra[i], rv[i]);
        wr(8'h04, 8'hff);
        wr(8'h05, 8'hff);
        wr(8'h06, 8'h00);
        wr(8'h0c, 8'hff);
        wr(8'h2d, 8'hff);
        wr(8'h27, 8'h55);
        chk(8'h04, 8'hb8);
        chk(8'h05, 8'hb2);
        chk(8'h06, 8'h40);
        chk(8'h0c, 8'h00);
        chk(8'h2d, 8'h00);
        chk(8'h25, 8'h55);
        for (int i = 0; i < 5; i++) begin
            wr(8'h04, 8'h00);
            wr(8'h05, {i[0], 1'b0, sz[i], 4'h2});
            x0 = xfers;
            d0 = dtcs;
            dn = 0;
            run(8'h01, ba[i]);
            chk(8'h07, 8'h00);
            chk(8'h00, 8'h08);
            req_n = 0;
            waitx(x0 + en[i]);
            poll(8'h80);
            req_n = 1;
            checks++;
            if (ls !== es[i] || lrd !== !i[0]
                || xfers != x0 + en[i] || dtcs != d0 + en[i] || !dn) bad("cycle shape");
            if (sz[i] == 2'h3 && la1 !== 1'b0) bad("address bit one set");
            chk(8'h0f, ea[i]);
            wr(8'h00, 8'h80);
        end
        wr(8'h05, 8'h02);
        x0 = xfers;
        run(8'h02, 8'h00);
        rdy_n = 1;
        req_n = 0;
        waitx(x0 + 1);
        req_n = 1;
        repeat (4) step;
        rdy_n = 0;
        repeat (30) step;
        checks++;
        if (xfers != x0 + 1) bad("burst kept going");
        chk(8'h00, 8'h08);
        wr(8'h07, 8'h10);
        chk(8'h00, 8'h90);
        chk(8'h01, 8'h11);
        wr(8'h07, 8'h80);
        chk(8'h07, 8'h00);
        wr(8'h00, 8'h00);
        chk(8'h00, 8'h90);
        wr(8'h00, 8'h10);
        chk(8'h00, 8'h80);
        chk(8'h01, 8'h00);
        wr(8'h00, 8'h80);
        fail = 1;
        run(8'h01, 8'h00);
        req_n = 0;
        poll(8'h80);
        req_n = 1;
        fail = 0;
        chk(8'h01, 8'h09);
        wr(8'h00, 8'h90);
        wr(8'h04, 8'h80);
        x0 = xfers;
        hold = 1;
        run(8'h03, 8'h00);
        pulse;
        pulse;
        hold = 0;
        waitx(x0 + 1);
        repeat (30) step;
        checks++;
        if (xfers != x0 + 1) bad("ignored edge served");
        o0 = ownr;
        rdy_n = 1;
        pulse;
        repeat (10) step;
        pulse;
        rdy_n = 0;
        poll(8'h80);
        checks++;
        if (xfers != x0 + 3 || ownr != o0 + 1) bad("bus not kept for new request");
        close_out;
    end
endmodule
